// ---- core/mdio_frame_slave.sv ----
// Management serial frame slave: decodes read and write frames into register strobes
`timescale 1ns/1ps
`include "phy_int_consts.svh"

module mdio_frame_slave #(
    parameter logic [4:0] PHY_ADDR = 5'h00
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic mdc_pin,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    output logic rd_req,
    output logic wr_req,
    output logic [4:0] reg_addr,
    output logic [15:0] wr_data,
    input wire logic [15:0] rd_data
);

    logic [2:0] mdc_sync; // Three-stage pin synchroniser for the serial clock
    logic [2:0] mdio_sync; // Three-stage pin synchroniser for the data pin
    logic mdc_level; // Debounced serial clock level
    phy_int_pkg::mdio_state_t state; // Frame phase
    logic [5:0] cnt; // Bit counter within a phase
    logic [12:0] hdr; // Start bit, opcode, port and register address
    logic [15:0] shift; // Data shifter, both directions
    logic match; // Frame addresses this port
    logic [2:0] next_mdc_sync;
    logic [2:0] next_mdio_sync;
    logic next_mdc_level;
    phy_int_pkg::mdio_state_t next_state;
    logic [5:0] next_cnt;
    logic [12:0] next_hdr;
    logic [15:0] next_shift;
    logic next_match;
    logic next_out;
    logic next_oe;
    logic next_rd;
    logic next_wr;
    logic agree; // Second and third stages agree
    logic rise; // Serial clock rising edge seen
    logic fall; // Serial clock falling edge seen
    logic bit_in; // Data bit taken at the rising edge

    // Edge detection and frame sequencing
    always_comb begin
        next_mdc_sync = {mdc_sync[1:0], mdc_pin};
        next_mdio_sync = {mdio_sync[1:0], mdio_in};
        agree = (mdc_sync[1] == mdc_sync[2]);
        next_mdc_level = agree ? mdc_sync[2] : mdc_level;
        rise = agree & mdc_sync[2] & ~mdc_level;
        fall = agree & ~mdc_sync[2] & mdc_level;
        bit_in = mdio_sync[2];
        next_state = state;
        next_cnt = cnt;
        next_hdr = hdr;
        next_shift = shift;
        next_match = match;
        next_out = mdio_out;
        next_oe = mdio_oe;
        next_rd = 1'b0;
        next_wr = 1'b0;
        case (state)
            phy_int_pkg::MDIO_PREAMBLE: begin
                // Count ones; a zero after a full preamble opens the frame
                if (rise) begin
                    if (bit_in) begin
                        next_cnt = (cnt == `PREAMBLE_BITS) ? cnt : cnt + 6'h01;
                    end else if (cnt == `PREAMBLE_BITS) begin
                        next_state = phy_int_pkg::MDIO_HEADER;
                        next_cnt = 6'h00;
                    end else begin
                        next_cnt = 6'h00;
                    end
                end
            end
            phy_int_pkg::MDIO_HEADER: begin
                // Collect second start bit, opcode and both addresses
                if (rise) begin
                    next_hdr = {hdr[11:0], bit_in};
                    next_cnt = cnt + 6'h01;
                    if (cnt == `HDR_LAST) begin
                        next_cnt = 6'h00;
                        next_match = next_hdr[12] && (next_hdr[9:5] == PHY_ADDR);
                        if (next_hdr[11:10] == `OP_READ && next_match) begin
                            next_rd = 1'b1;
                            next_state = phy_int_pkg::MDIO_READ;
                        end else if (next_hdr[11:10] == `OP_WRITE) begin
                            next_state = phy_int_pkg::MDIO_WRITE;
                        end else begin
                            next_state = phy_int_pkg::MDIO_PREAMBLE;
                        end
                    end
                end
            end
            phy_int_pkg::MDIO_READ: begin
                // Turnaround, then sixteen bits driven on falling edges
                if (fall) begin
                    next_cnt = cnt + 6'h01;
                    if (cnt == `RD_TA_DRIVE) begin
                        next_oe = 1'b1;
                        next_out = 1'b0;
                        next_shift = rd_data;
                    end else if (cnt == `RD_LAST) begin
                        next_oe = 1'b0;
                        next_out = 1'b0;
                        next_cnt = 6'h00;
                        next_state = phy_int_pkg::MDIO_PREAMBLE;
                    end else if (cnt > `RD_TA_DRIVE) begin
                        next_out = shift[15];
                        next_shift = {shift[14:0], 1'b0};
                    end
                end
            end
            phy_int_pkg::MDIO_WRITE: begin
                // Skip turnaround, shift in data; strobe only if addressed
                if (rise) begin
                    next_cnt = cnt + 6'h01;
                    if (cnt >= `WR_DATA_FIRST) begin
                        next_shift = {shift[14:0], bit_in};
                    end
                    if (cnt == `WR_LAST) begin
                        next_cnt = 6'h00;
                        next_wr = match;
                        next_state = phy_int_pkg::MDIO_PREAMBLE;
                    end
                end
            end
            default: begin
                next_state = phy_int_pkg::MDIO_PREAMBLE;
                next_cnt = 6'h00;
                next_oe = 1'b0;
            end
        endcase
    end

    // Frame state registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mdc_sync <= 3'h0;
            mdio_sync <= 3'h0;
            mdc_level <= 1'b0;
            state <= phy_int_pkg::MDIO_PREAMBLE;
            cnt <= 6'h00;
            hdr <= 13'h0000;
            shift <= 16'h0000;
            match <= 1'b0;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
            rd_req <= 1'b0;
            wr_req <= 1'b0;
        end else begin
            mdc_sync <= next_mdc_sync;
            mdio_sync <= next_mdio_sync;
            mdc_level <= next_mdc_level;
            state <= next_state;
            cnt <= next_cnt;
            hdr <= next_hdr;
            shift <= next_shift;
            match <= next_match;
            mdio_out <= next_out;
            mdio_oe <= next_oe;
            rd_req <= next_rd;
            wr_req <= next_wr;
        end
    end

    // Register address and write data come straight from the frame flops
    assign reg_addr = hdr[4:0];
    assign wr_data = shift;

endmodule : mdio_frame_slave

// ---- core/phy_port_interrupt_logic.sv ----
// Per-port interrupt logic: event latches, masks, enable and test force behind the management bus
`timescale 1ns/1ps
`include "phy_int_consts.svh"

// Contract
// (R1) Autoneg mask gates autoneg-done interrupt
// (R2) Speed mask gates speed-change interrupt
// (R3) Duplex mask gates duplex-change interrupt
// (R4) Link mask gates link-change interrupt
// (R5) Port enable gates all port interrupts; the code lets test force (R6) raise the interrupt with the port enable off
// (R6) Test force drives interrupt indication active
// (R7) Software writes zero to enable bits 15:8
// (R8) Software writes zero to enable bit 2
// (R9) Autoneg done latches, clears on read
// (R10) Speed change latches until status read
// (R11) Duplex change latches until status read
// (R12) Link change latches until status read
// (R13) Pending bit shows interrupt, clears on read
// (R14) Status read returns latched values, then clears
// (R15) Interrupt on enabled masked event or force
// (R16) After clearing read, interrupt drops unless renewed
module phy_port_interrupt_logic #(
    parameter logic [4:0] PHY_ADDR = 5'h00
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic MDC,
    input wire logic MDIO_IN,
    output logic MDIO_OUT,
    output logic MDIO_OE,
    input wire logic AN_COMPLETE,
    input wire logic SPEED_100,
    input wire logic FULL_DUPLEX,
    input wire logic LINK_UP,
    output logic INTERRUPT_OUT
);

    logic rd_req; // One-cycle read strobe from the serial slave
    logic wr_req; // One-cycle write strobe from the serial slave
    logic [4:0] reg_addr; // Register addressed by the current frame
    logic [15:0] wr_data; // Data of a write frame
    logic [15:0] rd_data; // Read answer held for the serial slave

    logic [7:0] mask; // Enable register bits 7:0
    logic [3:0] status; // Latched events: autoneg, speed, duplex, link
    logic [3:0] prev; // Last sampled line state
    logic primed; // Line state has been sampled once since reset
    logic pending; // Management interrupt indication

    logic [7:0] next_mask;
    logic [3:0] next_status;
    logic [3:0] next_prev;
    logic next_primed;
    logic next_pending;
    logic [15:0] next_rd_data;
    logic [3:0] ev; // Events seen this cycle
    logic status_read; // Status register read this cycle
    logic enable_write; // Enable register written this cycle

    // Serial management frame engine
    mdio_frame_slave #(
        .PHY_ADDR(PHY_ADDR)
    ) u_mdio (
        .clock(CLOCK),
        .reset(SYS_RST),
        .mdc_pin(MDC),
        .mdio_in(MDIO_IN),
        .mdio_out(MDIO_OUT),
        .mdio_oe(MDIO_OE),
        .rd_req(rd_req),
        .wr_req(wr_req),
        .reg_addr(reg_addr),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );

    // Event detection, latching, masking and register access
    always_comb begin
        next_prev = {AN_COMPLETE, SPEED_100, FULL_DUPLEX, LINK_UP};
        next_primed = 1'b1;
        // Events are ignored on the first cycle so the reset value of prev causes none
        ev = 4'h0;
        if (primed) begin
            ev[`EV_AN] = AN_COMPLETE & ~prev[`EV_AN]; // [R9]
            ev[`EV_SPEED] = SPEED_100 ^ prev[`EV_SPEED]; // [R10]
            ev[`EV_DUPLEX] = FULL_DUPLEX ^ prev[`EV_DUPLEX]; // [R11]
            ev[`EV_LINK] = LINK_UP ^ prev[`EV_LINK]; // [R12]
        end
        status_read = rd_req && (reg_addr == `REG_INT_STATUS);
        enable_write = wr_req && (reg_addr == `REG_INT_ENABLE);

        // Enable register keeps bits 7:0; upper bits are dropped
        next_mask = mask;
        if (enable_write) begin
            next_mask = wr_data[7:0];
        end

        // A read clears the latches, but an event in the same cycle still sets
        if (status_read) begin
            next_status = ev; // [R14]
        end else begin
            next_status = status | ev; // [R10] [R11] [R12]
        end

        // Interrupt: forced, or enabled with any latched event whose mask is set
        next_pending = next_mask[`BIT_TEST_FORCE] // [R6]
            | (next_mask[`BIT_PORT_INT_EN] // [R5]
            & (|(next_status & next_mask[`EVENT_MSB:`EVENT_LSB]))); // [R1] [R2] [R3] [R4] [R15] [R16]

        // Read answer captured on the strobe, before the latches clear
        next_rd_data = rd_data;
        if (rd_req) begin
            case (reg_addr)
                `REG_INT_ENABLE: begin
                    next_rd_data = {8'h00, mask};
                end
                `REG_INT_STATUS: begin
                    next_rd_data = {8'h00, status, 1'b0, pending, 2'h0}; // [R13] [R14]
                end
                default: begin
                    next_rd_data = 16'h0000;
                end
            endcase
        end
    end

    // Register state
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mask <= `ENABLE_RESET;
            status <= `STATUS_RESET;
            prev <= 4'h0;
            primed <= 1'b0;
            pending <= 1'b0;
            rd_data <= `READ_RESET;
        end else begin
            mask <= next_mask;
            status <= next_status;
            prev <= next_prev;
            primed <= next_primed;
            pending <= next_pending;
            rd_data <= next_rd_data;
        end
    end

    // Interrupt indication comes from its own flop
    assign INTERRUPT_OUT = pending;

    // Autoneg event reaches the output only when unmasked and enabled
    autoneg_mask_a: assert property ( // [R1]
        @(posedge CLOCK) disable iff (SYS_RST)
        (status[`EV_AN] && mask[`BIT_PORT_INT_EN] && !mask[`BIT_TEST_FORCE]
         && (status & mask[`EVENT_MSB:`EVENT_LSB] & 4'h7) == 4'h0)
        |-> (INTERRUPT_OUT == mask[`BIT_AN_MASK]))
        else $error("autoneg mask does not steer the interrupt");

    // Speed change event
    speed_mask_a: assert property ( // [R2]
        @(posedge CLOCK) disable iff (SYS_RST)
        (status[`EV_SPEED] && mask[`BIT_SPEED_MASK] && mask[`BIT_PORT_INT_EN]) |-> INTERRUPT_OUT)
        else $error("unmasked speed change gave no interrupt");

    // Duplex change event
    duplex_mask_a: assert property ( // [R3]
        @(posedge CLOCK) disable iff (SYS_RST)
        (status[`EV_DUPLEX] && mask[`BIT_DUPLEX_MASK] && mask[`BIT_PORT_INT_EN]) |-> INTERRUPT_OUT)
        else $error("unmasked duplex change gave no interrupt");

    // Link change event
    link_mask_a: assert property ( // [R4]
        @(posedge CLOCK) disable iff (SYS_RST)
        (status[`EV_LINK] && mask[`BIT_LINK_MASK] && mask[`BIT_PORT_INT_EN]) |-> INTERRUPT_OUT)
        else $error("unmasked link change gave no interrupt");

    // Port enable off and no force means no interrupt
    port_enable_a: assert property ( // [R5]
        @(posedge CLOCK) disable iff (SYS_RST)
        (!mask[`BIT_PORT_INT_EN] && !mask[`BIT_TEST_FORCE]) |-> !INTERRUPT_OUT)
        else $error("interrupt raised while port disabled");

    // Test force holds the indication active
    test_force_a: assert property ( // [R6]
        @(posedge CLOCK) disable iff (SYS_RST)
        mask[`BIT_TEST_FORCE] |-> INTERRUPT_OUT)
        else $error("test force did not raise the interrupt");

    // Speed line change is latched one cycle later
    speed_latch_a: assert property ( // [R10]
        @(posedge CLOCK) disable iff (SYS_RST)
        (primed && $changed(SPEED_100)) |=> status[`EV_SPEED])
        else $error("speed change not latched");

    // Latched link event stays until a status read
    link_hold_a: assert property ( // [R12]
        @(posedge CLOCK) disable iff (SYS_RST)
        (status[`EV_LINK] && !status_read) |=> status[`EV_LINK])
        else $error("link change latch lost without a read");

    // Status read returns the latched values and then clears them
    status_read_a: assert property ( // [R14]
        @(posedge CLOCK) disable iff (SYS_RST)
        status_read |=> (rd_data[`EVENT_MSB:`EVENT_LSB] == $past(status))
                        && (rd_data[`BIT_INT_PENDING] == $past(INTERRUPT_OUT)) // [R13]
                        && (status == $past(ev)))
        else $error("status read answer or clear wrong");

    // After a clearing read with no new event and no force the interrupt drops
    read_release_a: assert property ( // [R16]
        @(posedge CLOCK) disable iff (SYS_RST)
        (status_read && ev == 4'h0 && !mask[`BIT_TEST_FORCE]) |=> !INTERRUPT_OUT)
        else $error("interrupt held after clearing read");

    // Raised interrupt always has a cause
    int_cause_a: assert property ( // [R15]
        @(posedge CLOCK) disable iff (SYS_RST)
        $rose(INTERRUPT_OUT) |-> (mask[`BIT_TEST_FORCE]
            || (mask[`BIT_PORT_INT_EN] && (status & mask[`EVENT_MSB:`EVENT_LSB]) != 4'h0)))
        else $error("interrupt rose without a cause");

    // Latch and hold checks
    // Autoneg done latches
    autoneg_latch_a: assert property ( // [R9]
        @(posedge CLOCK) disable iff (SYS_RST)
        (primed && $rose(AN_COMPLETE)) |=> status[`EV_AN])
        else $error("autoneg done not latched");

    // Duplex change latches
    duplex_latch_a: assert property ( // [R11]
        @(posedge CLOCK) disable iff (SYS_RST)
        (primed && $changed(FULL_DUPLEX)) |=> status[`EV_DUPLEX])
        else $error("duplex change not latched");

    // Link change latches
    link_latch_a: assert property ( // [R12]
        @(posedge CLOCK) disable iff (SYS_RST)
        (primed && $changed(LINK_UP)) |=> status[`EV_LINK])
        else $error("link change not latched");

    // Autoneg latch held
    autoneg_hold_a: assert property ( // [R9]
        @(posedge CLOCK) disable iff (SYS_RST)
        (status[`EV_AN] && !status_read) |=> status[`EV_AN])
        else $error("autoneg latch lost");

    // Speed latch held
    speed_hold_a: assert property ( // [R10]
        @(posedge CLOCK) disable iff (SYS_RST)
        (status[`EV_SPEED] && !status_read) |=> status[`EV_SPEED])
        else $error("speed latch lost");

    // Duplex latch held
    duplex_hold_a: assert property ( // [R11]
        @(posedge CLOCK) disable iff (SYS_RST)
        (status[`EV_DUPLEX] && !status_read) |=> status[`EV_DUPLEX])
        else $error("duplex latch lost");

    // No event from the reset state
    reset_quiet_a: assert property ( // [R10] [R11] [R12]
        @(posedge CLOCK) disable iff (SYS_RST)
        !primed |=> (status == 4'h0))
        else $error("event latched from reset");

    // Mask, enable and read checks
    // Unmasked autoneg interrupts
    autoneg_raise_a: assert property ( // [R1]
        @(posedge CLOCK) disable iff (SYS_RST)
        (status[`EV_AN] && mask[`BIT_AN_MASK] && mask[`BIT_PORT_INT_EN]) |-> INTERRUPT_OUT)
        else $error("unmasked autoneg gave no interrupt");

    // Masked events stay silent
    masked_quiet_a: assert property ( // [R1] [R2] [R3] [R4]
        @(posedge CLOCK) disable iff (SYS_RST)
        (!mask[`BIT_TEST_FORCE] && (status & mask[`EVENT_MSB:`EVENT_LSB]) == 4'h0) |-> !INTERRUPT_OUT)
        else $error("masked event interrupted");

    // Any enabled unmasked event interrupts
    any_event_a: assert property ( // [R15]
        @(posedge CLOCK) disable iff (SYS_RST)
        (mask[`BIT_PORT_INT_EN] && (status & mask[`EVENT_MSB:`EVENT_LSB]) != 4'h0) |-> INTERRUPT_OUT)
        else $error("enabled event gave no interrupt");

    // Force survives a clearing read
    force_read_a: assert property ( // [R16]
        @(posedge CLOCK) disable iff (SYS_RST)
        (status_read && mask[`BIT_TEST_FORCE]) |=> INTERRUPT_OUT)
        else $error("force lost on read");

    // Enable write lands
    enable_write_a: assert property ( // [R5] [R6]
        @(posedge CLOCK) disable iff (SYS_RST)
        enable_write |=> (mask == wr_data[7:0]))
        else $error("enable write lost");

    // Enable read answers the stored bits
    enable_read_a: assert property ( // [R5]
        @(posedge CLOCK) disable iff (SYS_RST)
        (rd_req && reg_addr == `REG_INT_ENABLE) |=> (rd_data == {8'h00, $past(mask)}))
        else $error("enable read wrong");

    // Unused status bits read zero
    status_zero_a: assert property ( // [R14]
        @(posedge CLOCK) disable iff (SYS_RST)
        status_read |=> (rd_data[15:8] == 8'h00 && rd_data[3] == 1'b0 && rd_data[1:0] == 2'h0))
        else $error("status spare bits set");

endmodule : phy_port_interrupt_logic

// ---- shared/phy_int_consts.svh ----
// Register offsets, field positions, reset values and frame counts of the port interrupt logic
`ifndef PHY_INT_CONSTS_SVH
`define PHY_INT_CONSTS_SVH

// Management register offsets
`define REG_INT_ENABLE 5'h12
`define REG_INT_STATUS 5'h13

// Enable register field positions
`define BIT_AN_MASK 7
`define BIT_SPEED_MASK 6
`define BIT_DUPLEX_MASK 5
`define BIT_LINK_MASK 4
`define BIT_PORT_INT_EN 1
`define BIT_TEST_FORCE 0

// Status register field positions
`define EVENT_MSB 7
`define EVENT_LSB 4
`define BIT_INT_PENDING 2

// Event vector order: autoneg, speed, duplex, link
`define EV_AN 3
`define EV_SPEED 2
`define EV_DUPLEX 1
`define EV_LINK 0

// Reset values
`define ENABLE_RESET 8'h00
`define STATUS_RESET 4'h0
`define READ_RESET 16'h0000

// Serial frame counts and opcodes
`define PREAMBLE_BITS 6'h20
`define HDR_LAST 6'h0c
`define RD_TA_DRIVE 6'h01
`define RD_LAST 6'h12
`define WR_DATA_FIRST 6'h02
`define WR_LAST 6'h11
`define OP_READ 2'h2
`define OP_WRITE 2'h1

`endif

// ---- shared/phy_int_pkg.sv ----
// Types shared by the port interrupt logic and its serial management slave
package phy_int_pkg;

    // Phases of one management frame
    typedef enum logic [1:0] {
        MDIO_PREAMBLE,
        MDIO_HEADER,
        MDIO_READ,
        MDIO_WRITE
    } mdio_state_t;

endpackage : phy_int_pkg

// ---- verification/mgmt_station.sv ----
// Station management controller model: drives serial management frames into the port
`timescale 1ns/1ps
`include "phy_int_consts.svh"

module mgmt_station (
    input wire logic clock,
    input wire logic mdio_line,
    output logic mdc,
    output logic mdo,
    output logic mdo_en
);
    // Serial clock rests low between frames, data line released
    initial begin
        mdc = 1'b0;
        mdo = 1'b1;
        mdo_en = 1'b0;
    end

    // One bit period: data changes after the falling edge, sampled as the clock rises
    task automatic bit_slot(input logic val, input logic drive, output logic seen);
        @(negedge clock);
        mdc = 1'b0;
        mdo_en = drive;
        mdo = val;
        repeat (4) @(negedge clock);
        seen = mdio_line;
        mdc = 1'b1;
        repeat (4) @(negedge clock);
    endtask : bit_slot

    // Whole frame: preamble, header, turnaround and sixteen data bits, MSB first
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] reg_a,
                         input logic [15:0] wdata, output logic [15:0] rdata);
        logic [31:0] body;
        logic seen;
        body = {2'h1, op, phy, reg_a, 2'h2, wdata};
        rdata = 16'h0000;
        // Preamble of 32 ones before every frame
        for (int i = 0; i < 32; i++) begin
            bit_slot(1'b1, 1'b1, seen);
        end
        // Reads release the line from the turnaround on
        for (int i = 31; i >= 0; i--) begin
            bit_slot(body[i], (op == `OP_WRITE) || (i > 17), seen);
            if (i < 16) begin
                rdata[i] = seen;
            end
        end
        // Closing falling edge lets the port release the line
        @(negedge clock);
        mdc = 1'b0;
        mdo_en = 1'b0;
        repeat (4) @(negedge clock);
    endtask : frame

    // Register read
    task automatic read_reg(input logic [4:0] phy, input logic [4:0] reg_a, output logic [15:0] data);
        frame(`OP_READ, phy, reg_a, 16'h0000, data);
    endtask : read_reg

    // Register write; reserved enable bits always go out as zero
    task automatic write_reg(input logic [4:0] phy, input logic [4:0] reg_a, input logic [15:0] data);
        logic [15:0] unused;
        if (reg_a == `REG_INT_ENABLE) begin
            data = data & 16'h00fb;
        end
        frame(`OP_WRITE, phy, reg_a, data, unused);
    endtask : write_reg
endmodule : mgmt_station

// ---- verification/phy_port_interrupt_logic_tb.sv ----
// Self-checking bench for the port interrupt logic behind the management serial bus
`timescale 1ns/1ps
`include "phy_int_consts.svh"

module phy_port_interrupt_logic_tb;
    logic CLOCK, SYS_RST, MDC, MDIO_OUT, MDIO_OE, INTERRUPT_OUT; // Design pins
    logic AN_COMPLETE, SPEED_100, FULL_DUPLEX, LINK_UP; // Line state inputs
    logic st_out, st_oe, mdio_line; // Station drive and resolved data line
    logic [15:0] d; // Last read word
    int n_errors, compares, cycles; // Counters

    // Data line has a pull-up: high when neither side drives
    assign mdio_line = MDIO_OE ? MDIO_OUT : (st_oe ? st_out : 1'b1);

    phy_port_interrupt_logic #(.PHY_ADDR(5'h00)) uut (
        .CLOCK(CLOCK), .SYS_RST(SYS_RST), .MDC(MDC), .MDIO_IN(mdio_line), .MDIO_OUT(MDIO_OUT),
        .MDIO_OE(MDIO_OE), .AN_COMPLETE(AN_COMPLETE), .SPEED_100(SPEED_100),
        .FULL_DUPLEX(FULL_DUPLEX), .LINK_UP(LINK_UP), .INTERRUPT_OUT(INTERRUPT_OUT)
    );

    mgmt_station st (.clock(CLOCK), .mdio_line(mdio_line), .mdc(MDC), .mdo(st_out), .mdo_en(st_oe));

    // 10 MHz clock
    initial begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check

    // Interrupt pin as a word for comparison
    function automatic logic [15:0] irq();
        return {15'h0000, INTERRUPT_OUT};
    endfunction : irq

    // One line event; autoneg counts only on its rising edge
    task automatic fire(input int e);
        @(negedge CLOCK);
        case (e)
            `EV_AN: AN_COMPLETE = 1'b1;
            `EV_SPEED: SPEED_100 = ~SPEED_100;
            `EV_DUPLEX: FULL_DUPLEX = ~FULL_DUPLEX;
            default: LINK_UP = ~LINK_UP;
        endcase
        @(negedge CLOCK);
        AN_COMPLETE = 1'b0;
        repeat (2) @(negedge CLOCK);
    endtask : fire

    // Reset values, unmapped register and a foreign port address
    task automatic t_reset();
        check(irq(), 16'h0000, "irq after reset");
        st.read_reg(5'h00, `REG_INT_ENABLE, d);
        check(d, `READ_RESET, "enable reset");
        st.read_reg(5'h00, `REG_INT_STATUS, d);
        check(d, 16'h0000, "status reset");
        st.read_reg(5'h00, 5'h14, d);
        check(d, 16'h0000, "unmapped read");
        st.read_reg(5'h01, `REG_INT_STATUS, d);
        check(d, 16'hffff, "foreign address");
        st.write_reg(5'h01, `REG_INT_ENABLE, 16'h00f3);
        st.read_reg(5'h00, `REG_INT_ENABLE, d);
        check(d, `READ_RESET, "foreign write");
        $display("test reset done");
    endtask : t_reset

    // Each mask alone: masked event latches silently, unmasked one interrupts
    task automatic t_masks();
        int o;
        for (int e = 0; e < 4; e++) begin
            o = (e + 1) % 4;
            st.write_reg(5'h00, `REG_INT_ENABLE, 16'h0002 | (16'h0010 << e));
            st.read_reg(5'h00, `REG_INT_ENABLE, d);
            check(d, 16'h0002 | (16'h0010 << e), "enable readback");
            st.read_reg(5'h00, `REG_INT_STATUS, d);
            fire(o);
            check(irq(), 16'h0000, "masked event");
            fire(e);
            check(irq(), 16'h0001, "unmasked event");
            st.read_reg(5'h00, `REG_INT_STATUS, d);
            check(d, (16'h0010 << e) | (16'h0010 << o) | 16'h0004, "latched");
            check(irq(), 16'h0000, "irq after read");
            st.read_reg(5'h00, `REG_INT_STATUS, d);
            check(d, 16'h0000, "cleared by read");
        end
        $display("test masks done");
    endtask : t_masks

    // Port enable gates an unmasked link event; enabling later raises the held event
    task automatic t_enable();
        st.write_reg(5'h00, `REG_INT_ENABLE, 16'h00f0);
        st.read_reg(5'h00, `REG_INT_STATUS, d);
        fire(`EV_LINK);
        check(irq(), 16'h0000, "port disabled");
        st.write_reg(5'h00, `REG_INT_ENABLE, 16'h00f2);
        check(irq(), 16'h0001, "port enabled");
        st.read_reg(5'h00, `REG_INT_STATUS, d);
        check(d, 16'h0014, "held link event");
        check(irq(), 16'h0000, "irq after read");
        $display("test enable done");
    endtask : t_enable

    // Test force holds the indication through a status read
    task automatic t_force();
        st.write_reg(5'h00, `REG_INT_ENABLE, 16'h0001);
        check(irq(), 16'h0001, "forced");
        st.read_reg(5'h00, `REG_INT_STATUS, d);
        check(d, 16'h0004, "pending forced");
        check(irq(), 16'h0001, "force after read");
        st.write_reg(5'h00, `REG_INT_ENABLE, 16'h0000);
        check(irq(), 16'h0000, "force removed");
        $display("test force done");
    endtask : t_force

    // Counts, verdict and end of run
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    // Hang guard, well above the roughly 19200 cycles of the tests
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            $display("unexpected at %0t: timeout", $time);
            report_and_stop();
        end
    end

    // Main sequence
    initial begin
        SYS_RST = 1'b1;
        AN_COMPLETE = 1'b0;
        SPEED_100 = 1'b0;
        FULL_DUPLEX = 1'b0;
        LINK_UP = 1'b0;
        n_errors = 0;
        compares = 0;
        cycles = 0;
        repeat (2) @(negedge CLOCK);
        SYS_RST = 1'b0;
        repeat (2) @(negedge CLOCK);
        t_reset();
        t_masks();
        t_enable();
        t_force();
        report_and_stop();
    end
endmodule : phy_port_interrupt_logic_tb
